// ### hw/breaker_failure_trigger_defines.vh
// Constants for the breaker failure trigger: offsets, fields, reset values and timing.
//
// Operation
// - Supervise breaker after trip, retrip if needed
// - Failed retrip raises breaker failure output
// - Retrip output can be disabled
// - Triggers: current, relays, signals, combinations
// - Evaluate three phases and chosen residual
// - Any selected binary signal may trigger
// - Selected output relay control may trigger
// - Compare fundamental magnitudes only
// - Residual source: input one, two, calculated
// - Measurements refreshed every 5 ms
// - Signal selection honoured only in signal modes
// - Relay selection honoured only in relay modes
// - Monitoring selections static, no setting groups
// - Forcing overrides reported state when enabled
// - Release at 97 percent, shared threshold
// - Blocked at pick-up stops processing
// - One pick-up starts both timers together
`ifndef BREAKER_FAILURE_TRIGGER_DEFINES_VH
`define BREAKER_FAILURE_TRIGGER_DEFINES_VH

// Register byte offsets.
`define BFT_REG_CTRL        8'h00
`define BFT_REG_PHASE_THR   8'h04
`define BFT_REG_RES_THR     8'h08
`define BFT_REG_SIG_SEL     8'h0C
`define BFT_REG_RELAY_SEL   8'h10
`define BFT_REG_RETRIP_TIME 8'h14
`define BFT_REG_BF_TIME     8'h18
`define BFT_REG_STATUS      8'h1C
`define BFT_REG_IRQ_STAT    8'h20
`define BFT_REG_IRQ_CLR     8'h24
`define BFT_REG_IRQ_EN      8'h28

// Control register fields.
`define BFT_CTRL_MODE_LSB   0
`define BFT_CTRL_MODE_MSB   3
`define BFT_CTRL_RES_LSB    4
`define BFT_CTRL_RES_MSB    5
`define BFT_CTRL_RETRIP_EN  6
`define BFT_CTRL_FORCE_EN   7
`define BFT_CTRL_FORCE_LSB  8
`define BFT_CTRL_FORCE_MSB  10
`define BFT_CTRL_RESET      11'h040

// Residual source codes.
`define BFT_RES_NONE        2'h0
`define BFT_RES_ONE         2'h1
`define BFT_RES_TWO         2'h2
`define BFT_RES_CALC        2'h3

// Forced state codes.
`define BFT_FORCE_NORMAL    3'h0
`define BFT_FORCE_START     3'h1
`define BFT_FORCE_RETRIP    3'h2
`define BFT_FORCE_BF        3'h3
`define BFT_FORCE_BLOCKED   3'h4

// Reset values of thresholds and timers (timers in 5 ms ticks).
`define BFT_THR_RESET       16'h0014
`define BFT_RES_THR_RESET   16'h0078
`define BFT_RETRIP_RESET    16'h0014
`define BFT_BF_RESET        16'h0028

// Hysteresis: release below 97 of 100 parts of the threshold.
`define BFT_HYST_NUM        7'h61
`define BFT_HYST_DEN        7'h64

// Measurement time base.
`define BFT_TICK_MS         5
`define BFT_CLK_PERIOD_NS   10
`define BFT_TICK_CYCLES     (`BFT_TICK_MS * 1000000 / `BFT_CLK_PERIOD_NS)

`endif

// ### hw/breaker_failure_trigger.v
// Breaker failure trigger: pick-up, retrip and backup trip logic with an APB register file.
`timescale 1ns/1ps
`default_nettype none
`include "breaker_failure_trigger_defines.vh"

module breaker_failure_trigger #(
	parameter W           = 16,
	parameter NSIG        = 16,
	parameter NREL        = 8,
	parameter TICK_CYCLES = `BFT_TICK_CYCLES
) (
	input  wire            i_clk,
	input  wire            i_nrst,
	input  wire            i_psel,
	input  wire            i_penable,
	input  wire            i_pwrite,
	input  wire [7:0]      i_paddr,
	input  wire [31:0]     i_pwdata,
	output reg  [31:0]     o_prdata,
	output reg             o_pready,
	output reg             o_pslverr,
	input  wire [W-1:0]    i_phase_a_current,
	input  wire [W-1:0]    i_phase_b_current,
	input  wire [W-1:0]    i_phase_c_current,
	input  wire [W-1:0]    i_residual_input_one,
	input  wire [W-1:0]    i_residual_input_two,
	input  wire [W-1:0]    i_calculated_residual,
	input  wire [NSIG-1:0] i_trip_signals,
	input  wire [NREL-1:0] i_relay_ctrl,
	input  wire            i_block,
	output reg             o_retrip,
	output reg             o_breaker_failure_output,
	output reg  [4:0]      o_condition,
	output reg             o_irq
);

	// **********************************************************************
	// Local constants
	// **********************************************************************
	localparam [4:0] ST_NORMAL  = 5'h01;
	localparam [4:0] ST_START   = 5'h02;
	localparam [4:0] ST_RETRIP  = 5'h04;
	localparam [4:0] ST_BF      = 5'h08;
	localparam [4:0] ST_BLOCKED = 5'h10;
	localparam [19:0] TICK_LAST = TICK_CYCLES[19:0] - 20'h00001;
	localparam MW = W + 7;

	// **********************************************************************
	// Registers and nets
	// **********************************************************************
	reg  [10:0]     ctrl_q;
	reg  [15:0]     phase_thr_q;
	reg  [15:0]     res_thr_q;
	reg  [NSIG-1:0] sig_sel_q;
	reg  [NREL-1:0] relay_sel_q;
	reg  [15:0]     retrip_time_q;
	reg  [15:0]     bf_time_q;
	reg  [3:0]      irq_stat_q;
	reg  [3:0]      irq_en_q;
	reg  [19:0]     tick_cnt_q;
	reg             tick_q;
	reg  [4*W-1:0]  meas_q;
	reg  [3:0]      pick_q;
	reg  [4:0]      state_q;
	reg  [4:0]      state_d;
	reg  [15:0]     timer_q;
	reg  [W-1:0]    res_mux;
	reg  [2:0]      use_src;
	reg             and_op;
	reg  [4:0]      cond_d;
	reg  [31:0]     rdata_d;
	reg             bad_addr;
	wire [3:0]      mode;
	wire [1:0]      res_sel;
	wire [2:0]      force_code;
	wire            setup;
	wire            wr_en;
	wire            cur_cond;
	wire            sig_cond;
	wire            rel_cond;
	wire            pickup;
	wire [3:0]      events;
	wire [3:0]      clr_bits;
	wire [4*W-1:0]  meas_in;

	assign mode       = ctrl_q[`BFT_CTRL_MODE_MSB:`BFT_CTRL_MODE_LSB];
	assign res_sel    = ctrl_q[`BFT_CTRL_RES_MSB:`BFT_CTRL_RES_LSB];
	assign force_code = ctrl_q[`BFT_CTRL_FORCE_MSB:`BFT_CTRL_FORCE_LSB];
	assign setup      = i_psel & ~i_penable;
	assign wr_en      = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

	// **********************************************************************
	// Measurement time base and sampling
	// **********************************************************************

	// The divider gives a one-cycle tick every 5 ms; all timing runs on it.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_cnt_q <= 20'h00000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= 20'h00000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 20'h00001;
			tick_q     <= 1'b0;
		end
	end

	// Residual source picks input one, two or the calculated value.
	always @* begin
		case (res_sel)
			`BFT_RES_ONE:  res_mux = i_residual_input_one;
			`BFT_RES_TWO:  res_mux = i_residual_input_two;
			`BFT_RES_CALC: res_mux = i_calculated_residual;
			default:       res_mux = {W{1'b0}};
		endcase
	end

	assign meas_in = {res_mux, i_phase_c_current, i_phase_b_current, i_phase_a_current};

	// **********************************************************************
	// Per-channel pick-up with hysteresis
	// **********************************************************************
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			wire [15:0] thr;
			wire [W-1:0] m;
			wire [MW-1:0] m_scaled;
			wire [MW-1:0] thr_rel;
			wire above;
			wire hold;
			assign thr      = (g == 3) ? res_thr_q : phase_thr_q;
			assign m        = meas_q[g*W +: W];
			assign m_scaled = m * `BFT_HYST_DEN;
			assign thr_rel  = thr * `BFT_HYST_NUM;
			assign above    = ({7'h00, m} > {{(MW-16){1'b0}}, thr});
			assign hold     = (m_scaled >= thr_rel);

			// Magnitudes are latched on the tick; pick-up releases below 97 percent.
			always @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					meas_q[g*W +: W] <= {W{1'b0}};
					pick_q[g]        <= 1'b0;
				end else if (tick_q) begin
					meas_q[g*W +: W] <= meas_in[g*W +: W];
					if (g == 3 && res_sel == `BFT_RES_NONE)
						pick_q[g] <= 1'b0;
					else
						pick_q[g] <= pick_q[g] ? hold : above;
				end
			end
		end
	endgenerate

	// **********************************************************************
	// Trigger combination
	// **********************************************************************
	assign cur_cond = |pick_q;
	assign sig_cond = |(i_trip_signals & sig_sel_q);
	assign rel_cond = |(i_relay_ctrl & relay_sel_q);

	// Mode decodes to the sources in use and whether they are ANDed or ORed.
	always @* begin
		and_op = 1'b0;
		case (mode)
			4'h0:    use_src = 3'b001;
			4'h1:    use_src = 3'b100;
			4'h2:    use_src = 3'b010;
			4'h3:    begin use_src = 3'b101; and_op = 1'b1; end
			4'h4:    use_src = 3'b101;
			4'h5:    begin use_src = 3'b011; and_op = 1'b1; end
			4'h6:    use_src = 3'b011;
			4'h7:    begin use_src = 3'b110; and_op = 1'b1; end
			4'h8:    use_src = 3'b110;
			4'h9:    begin use_src = 3'b111; and_op = 1'b1; end
			4'hA:    use_src = 3'b111;
			default: use_src = 3'b001;
		endcase
	end

	// Unused sources drop out: neutral 1 for AND, neutral 0 for OR.
	assign pickup = and_op ?
		((cur_cond | ~use_src[0]) & (sig_cond | ~use_src[1]) & (rel_cond | ~use_src[2])) :
		((cur_cond & use_src[0]) | (sig_cond & use_src[1]) | (rel_cond & use_src[2]));

	// **********************************************************************
	// Supervision state machine
	// **********************************************************************

	// Next state: release wins, blocking at pick-up stops, timers promote.
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_NORMAL: begin
				if (pickup)
					state_d = i_block ? ST_BLOCKED : ST_START;
			end
			ST_START: begin
				if (!pickup)
					state_d = ST_NORMAL;
				else if (i_block)
					state_d = ST_NORMAL;
				else if (timer_q >= bf_time_q)
					state_d = ST_BF;
				else if (ctrl_q[`BFT_CTRL_RETRIP_EN] && timer_q >= retrip_time_q)
					state_d = ST_RETRIP;
			end
			ST_RETRIP: begin
				if (!pickup || i_block)
					state_d = ST_NORMAL;
				else if (timer_q >= bf_time_q)
					state_d = ST_BF;
			end
			ST_BF: begin
				if (!pickup || i_block)
					state_d = ST_NORMAL;
			end
			ST_BLOCKED: begin
				if (!pickup)
					state_d = ST_NORMAL;
			end
			default: state_d = ST_NORMAL;
		endcase
	end

	// One timer measures both delays from the common pick-up.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_NORMAL;
			timer_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_d == ST_NORMAL || state_d == ST_BLOCKED)
				timer_q <= 16'h0000;
			else if (tick_q && timer_q != 16'hFFFF)
				timer_q <= timer_q + 16'h0001;
		end
	end

	// Reported condition, overridden while forcing is enabled.
	always @* begin
		cond_d = state_q;
		if (ctrl_q[`BFT_CTRL_FORCE_EN]) begin
			case (force_code)
				`BFT_FORCE_START:   cond_d = ST_START;
				`BFT_FORCE_RETRIP:  cond_d = ST_RETRIP;
				`BFT_FORCE_BF:      cond_d = ST_BF;
				`BFT_FORCE_BLOCKED: cond_d = ST_BLOCKED;
				default:            cond_d = ST_NORMAL;
			endcase
		end
	end

	// Outputs are registered copies of the reported condition.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_condition              <= ST_NORMAL;
			o_retrip                 <= 1'b0;
			o_breaker_failure_output <= 1'b0;
		end else begin
			o_condition              <= cond_d;
			o_retrip                 <= (cond_d == ST_RETRIP);
			o_breaker_failure_output <= (cond_d == ST_BF);
		end
	end

	// **********************************************************************
	// Interrupts
	// **********************************************************************
	assign events   = {state_d == ST_BLOCKED, state_d == ST_BF, state_d == ST_RETRIP,
		state_d == ST_START} & ~{state_q == ST_BLOCKED, state_q == ST_BF,
		state_q == ST_RETRIP, state_q == ST_START};
	assign clr_bits = (wr_en && i_paddr == `BFT_REG_IRQ_CLR) ? i_pwdata[3:0] : 4'h0;

	// Sticky status: a new event in the clear cycle survives the clear.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_stat_q <= 4'h0;
			o_irq      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr_bits) | events;
			o_irq      <= |(((irq_stat_q & ~clr_bits) | events) & irq_en_q);
		end
	end

	// **********************************************************************
	// APB register file
	// **********************************************************************

	// Settings are static; nothing but a bus write changes them.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q        <= `BFT_CTRL_RESET;
			phase_thr_q   <= `BFT_THR_RESET;
			res_thr_q     <= `BFT_RES_THR_RESET;
			sig_sel_q     <= {NSIG{1'b0}};
			relay_sel_q   <= {NREL{1'b0}};
			retrip_time_q <= `BFT_RETRIP_RESET;
			bf_time_q     <= `BFT_BF_RESET;
			irq_en_q      <= 4'h0;
		end else if (wr_en) begin
			case (i_paddr)
				`BFT_REG_CTRL:        ctrl_q        <= i_pwdata[10:0];
				`BFT_REG_PHASE_THR:   phase_thr_q   <= i_pwdata[15:0];
				`BFT_REG_RES_THR:     res_thr_q     <= i_pwdata[15:0];
				`BFT_REG_SIG_SEL:     sig_sel_q     <= i_pwdata[NSIG-1:0];
				`BFT_REG_RELAY_SEL:   relay_sel_q   <= i_pwdata[NREL-1:0];
				`BFT_REG_RETRIP_TIME: retrip_time_q <= i_pwdata[15:0];
				`BFT_REG_BF_TIME:     bf_time_q     <= i_pwdata[15:0];
				`BFT_REG_IRQ_EN:      irq_en_q      <= i_pwdata[3:0];
				default:              ctrl_q        <= ctrl_q;
			endcase
		end
	end

	// Read mux and address check.
	always @* begin
		rdata_d  = 32'h00000000;
		bad_addr = 1'b0;
		case (i_paddr)
			`BFT_REG_CTRL:        rdata_d[10:0] = ctrl_q;
			`BFT_REG_PHASE_THR:   rdata_d[15:0] = phase_thr_q;
			`BFT_REG_RES_THR:     rdata_d[15:0] = res_thr_q;
			`BFT_REG_SIG_SEL:     rdata_d[NSIG-1:0] = sig_sel_q;
			`BFT_REG_RELAY_SEL:   rdata_d[NREL-1:0] = relay_sel_q;
			`BFT_REG_RETRIP_TIME: rdata_d[15:0] = retrip_time_q;
			`BFT_REG_BF_TIME:     rdata_d[15:0] = bf_time_q;
			`BFT_REG_STATUS:      rdata_d[24:0] = {timer_q, pick_q, o_condition};
			`BFT_REG_IRQ_STAT:    rdata_d[3:0] = irq_stat_q;
			`BFT_REG_IRQ_CLR:     rdata_d = 32'h00000000;
			`BFT_REG_IRQ_EN:      rdata_d[3:0] = irq_en_q;
			default:              bad_addr = 1'b1;
		endcase
	end

	// Every access gets one wait-free access phase; data is captured at setup.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup & bad_addr;
			if (setup)
				o_prdata <= i_pwrite ? 32'h00000000 : rdata_d;
		end
	end

endmodule // breaker_failure_trigger
`default_nettype wire

// ### sim/breaker_failure_trigger_asserts.sv
// Port checks for the breaker failure trigger.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_trigger_asserts (
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_block,
	input wire logic        o_retrip,
	input wire logic        o_breaker_failure_output,
	input wire logic [4:0]  o_condition
);
	logic force_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Tracks forcing so that forced states are not taken for real ones.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			force_q <= 1'b0;
		else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h00)
			force_q <= i_pwdata[7];
	end
	// Bus answer timing and refusals.
	a_pready_answer: assert property (i_psel && !i_penable |=> o_pready)
		else $error("ready missing after setup");
	a_pready_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_unmapped_error: assert property (o_pready && i_paddr > 8'h28 |-> o_pslverr && o_prdata == 0)
		else $error("unmapped access not refused");
	a_clear_reads_zero: assert property (o_pready && !i_pwrite && i_paddr == 8'h24 |-> o_prdata == 0)
		else $error("clear register read not zero");
	// Outputs follow the reported state.
	a_retrip_level: assert property (o_retrip == (o_condition == 5'h04))
		else $error("retrip output disagrees with state");
	a_backup_level: assert property (o_breaker_failure_output == (o_condition == 5'h08))
		else $error("backup output disagrees with state");
	a_state_onehot: assert property ($onehot(o_condition))
		else $error("reported state not one-hot");
	a_block_release: assert property ((!force_q && i_block) [*3] |-> !o_retrip && !o_breaker_failure_output)
		else $error("trip output while blocked");
	// Main scenarios reached.
	c_backup: cover property (o_condition == 5'h08);
	c_blocked: cover property (o_condition == 5'h10);
	c_refused: cover property (o_pready && o_pslverr);
endmodule // breaker_failure_trigger_asserts
`default_nettype wire

// ### sim/breaker_model.sv
// Breaker model: fault current that a coil or the upstream breaker interrupts.
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic [15:0] i_level,
	input  wire logic        i_stuck,
	input  wire logic        i_slow,
	input  wire logic        i_retrip,
	input  wire logic        i_bf,
	output wire logic [15:0] o_current
);
	logic       open_q;
	logic [1:0] cnt_q;
	// A stuck breaker ignores its second coil; a slow one needs four cycles to part.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			open_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (i_level == 16'h0) begin
			open_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if ((i_retrip && !i_stuck) || i_bf) begin
			cnt_q <= cnt_q + 2'h1;
			open_q <= open_q || !i_slow || cnt_q == 2'h3;
		end
	end
	// Current flows only while the contacts are closed.
	assign o_current = open_q ? 16'h0 : i_level;
endmodule // breaker_model
`default_nettype wire

// ### sim/breaker_failure_trigger_tb.sv
// Self-checking bench for the breaker failure trigger.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_trigger_tb;
	localparam int TK = 4;
	logic        i_clk = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0, blk = 0, stk = 0, slow = 0;
	logic        c, s, d, pr, pe, rt, bf, irq, rerr;
	logic [4:0]  cond, seen;
	logic [7:0]  adr = 8'h00, rel = 8'h00;
	logic [15:0] lvl = 16'h0, r1 = 16'h0, r2 = 16'h0, rc = 16'h0, sig = 16'h0, ia;
	logic [31:0] wd = 32'h0, rdat, pd;
	logic [31:0] rv [7] = '{32'h40, 32'h14, 32'h78, 32'h0, 32'h0, 32'h14, 32'h28};
	int          err_total = 0, compares = 0, seed = 3072, n, t;

	breaker_failure_trigger #(.TICK_CYCLES(TK)) i_breaker_failure_trigger (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(adr), .i_pwdata(wd), .o_prdata(pd), .o_pready(pr), .o_pslverr(pe),
		.i_phase_a_current(ia), .i_phase_b_current(ia), .i_phase_c_current(ia),
		.i_residual_input_one(r1), .i_residual_input_two(r2), .i_calculated_residual(rc),
		.i_trip_signals(sig), .i_relay_ctrl(rel), .i_block(blk), .o_retrip(rt),
		.o_breaker_failure_output(bf), .o_condition(cond), .o_irq(irq));
	breaker_model i_breaker_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_level(lvl),
		.i_stuck(stk), .i_slow(slow), .i_retrip(rt), .i_bf(bf), .o_current(ia));

	// Clock, and a guard that ends a hung run.
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (40000) @(posedge i_clk);
		err_total++;
		end_of_test();
	end

	// Comparison, bus cycle and waiting helpers.
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		int k;
		@(posedge i_clk);
		psel <= 1;
		pwr <= w;
		adr <= a;
		wd <= dt;
		@(posedge i_clk);
		pen <= 1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (pr !== 1'b1 && k < 40);
		rdat = pd;
		rerr = pe;
		psel <= 0;
		pen <= 0;
		if (k >= 40) err_total++;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk($sformatf("register %h", a), rdat, exp);
	endtask
	task cyc(input int x);
		repeat (x) @(posedge i_clk);
	endtask
	task waitc(input logic [4:0] e, input int lim);
		int k;
		k = 0;
		while (cond !== e && k < lim) begin
			@(posedge i_clk);
			seen = seen | cond;
			k++;
		end
		chk("condition", cond, e);
	endtask
	// Expected pick-up of each trigger mode.
	function automatic logic pick(input int md, input logic cu, input logic sg, input logic dq);
		case (md)
			1: return dq;
			2: return sg;
			3: return cu & dq;
			4: return cu | dq;
			5: return cu & sg;
			6: return cu | sg;
			7: return sg & dq;
			8: return sg | dq;
			9: return cu & sg & dq;
			10: return cu | sg | dq;
			default: return cu;
		endcase
	endfunction
	task end_of_test();
		$display("mismatches %0d of %0d compares", err_total, compares);
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (8) @(posedge i_clk);
		i_nrst <= 1;
		foreach (rv[i]) rd(8'(i * 4), rv[i]);
		rd(8'h3C, 32'h0);
		chk("slave error", rerr, 1'b1);
		// Every trigger mode against random current, signal and relay states.
		apb(1, 8'h14, 32'h100);
		apb(1, 8'h18, 32'h100);
		apb(1, 8'h04, 32'h64);
		for (int md = 0; md < 12; md++) begin
			t = {$random(seed)} % 16;
			n = {$random(seed)} % 8;
			{c, s, d} = 3'($random(seed));
			apb(1, 8'h0C, 32'h1 << t);
			apb(1, 8'h10, 32'h1 << n);
			apb(1, 8'h00, 32'h40 | md);
			rd(8'h0C, 32'h1 << t);
			lvl <= c ? 16'h65 : 16'h64;
			sig <= (16'(s) << t) | (16'h1 << ((t + 1) % 16));
			rel <= (8'(d) << n) | (8'h1 << ((n + 1) % 8));
			cyc(3 * TK + 4);
			waitc(pick(md, c, s, d) ? 5'h02 : 5'h01, 4);
			lvl <= 0;
			sig <= 0;
			rel <= 0;
			waitc(5'h01, 3 * TK + 8);
		end
		// Residual source selection against one live residual input.
		for (int src = 0; src < 4; src++) begin
			n = ($random(seed) & 1) ? src : 1 + src % 3;
			apb(1, 8'h00, 32'h40 | (src << 4));
			r1 <= (n == 1) ? 16'h79 : 16'h78;
			r2 <= (n == 2) ? 16'h79 : 16'h78;
			rc <= (n == 3) ? 16'h79 : 16'h78;
			cyc(3 * TK + 4);
			waitc((n == src && src != 0) ? 5'h02 : 5'h01, 4);
			r1 <= 0;
			r2 <= 0;
			rc <= 0;
			waitc(5'h01, 3 * TK + 8);
		end
		// Pick-up above threshold, hold at 97 percent, release just below.
		apb(1, 8'h00, 32'h40);
		lvl <= 16'h65;
		waitc(5'h02, 3 * TK + 8);
		lvl <= 16'h61;
		cyc(3 * TK + 4);
		waitc(5'h02, 1);
		lvl <= 16'h60;
		waitc(5'h01, 3 * TK + 8);
		lvl <= 0;
		// Breaker clears on retrip, sticks, or has a single coil.
		apb(1, 8'h14, 32'h2);
		apb(1, 8'h18, 32'h8);
		for (int sc = 0; sc < 3; sc++) begin
			apb(1, 8'h00, (sc == 2) ? 32'h0 : 32'h40);
			apb(1, 8'h24, 32'hF);
			stk <= (sc != 0);
			slow <= 1'($random(seed));
			seen = 5'h0;
			lvl <= 16'h200;
			waitc(5'h02, 3 * TK + 8);
			waitc((sc == 2) ? 5'h08 : 5'h04, 10 * TK);
			if (sc == 1) waitc(5'h08, 10 * TK);
			waitc(5'h01, 6 * TK);
			chk("retrip seen", seen[2], sc != 2);
			chk("backup seen", seen[3], sc != 0);
			rd(8'h20, 32'({sc != 0, sc != 2, 1'b1}));
			lvl <= 0;
			cyc(2);
		end
		// Blocking at pick-up, then blocking a started supervision.
		blk <= 1;
		lvl <= 16'h200;
		waitc(5'h10, 3 * TK + 8);
		blk <= 0;
		cyc(4);
		waitc(5'h10, 1);
		lvl <= 0;
		waitc(5'h01, 3 * TK + 8);
		lvl <= 16'h200;
		waitc(5'h02, 3 * TK + 8);
		blk <= 1;
		waitc(5'h10, 6);
		blk <= 0;
		lvl <= 0;
		waitc(5'h01, 3 * TK + 8);
		// Forced states, then the same code with forcing off.
		for (int fc = 0; fc < 5; fc++) begin
			apb(1, 8'h00, 32'hC0 | 32'(fc << 8));
			cyc(3);
			chk("forced", cond, 5'h01 << fc);
			apb(1, 8'h00, 32'h40 | 32'(fc << 8));
			cyc(3);
			chk("unforced", cond, 5'h01);
		end
		// Interrupt event, mask, read-only write and clear.
		apb(1, 8'h14, 32'h100);
		apb(1, 8'h24, 32'hF);
		apb(1, 8'h28, 32'h1);
		rd(8'h20, 32'h0);
		lvl <= 16'h200;
		waitc(5'h02, 3 * TK + 8);
		lvl <= 0;
		rd(8'h20, 32'h1);
		chk("irq", irq, 1'b1);
		apb(1, 8'h28, 32'h0);
		cyc(2);
		chk("irq masked", irq, 1'b0);
		apb(1, 8'h28, 32'h1);
		apb(1, 8'h20, 32'h0);
		rd(8'h20, 32'h1);
		apb(1, 8'h24, 32'h1);
		cyc(1);
		chk("irq cleared", irq, 1'b0);
		rd(8'h20, 32'h0);
		rd(8'h1C, 32'h1);
		end_of_test();
	end
endmodule // breaker_failure_trigger_tb

bind breaker_failure_trigger breaker_failure_trigger_asserts i_chk (.i_clk(i_clk),
	.i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_block(i_block), .o_retrip(o_retrip),
	.o_breaker_failure_output(o_breaker_failure_output), .o_condition(o_condition));
`default_nettype wire
